// [hw/rtc_trim_alarm.sv]
// temperature trim control and time-of-day alarm
// ********************************************************************
// Overview of operation
// - battery sensing runs every ten minutes, or every minute when rate bit set.
// - with battery sense enable clear, no periodic battery sensing happens.
// - each battery conversion takes about 22 ms before trims are applied.
// - gain scales analog steps: zero unity, sixteenths down to one sixteenth, up to double.
// - a gain written with temp sense enable at 1 is used from the next sense cycle onward.
// - final analog trim reads six bits, upper two bits zero.
// - host writes to both trim monitors are ignored.
// - final digital trim reads five bits, upper three bits zero.
// - digital trim is sign and magnitude, magnitude 0 to 10.
// - alarm bytes at 10h..15h mirror calendar bytes, msb enables compare.
// - no year alarm; six fields seconds through weekday.
// - only enabled fields compare, others are don't-care.
// - alarm fires when at least one field is enabled and every enabled field equals the running calendar.
// - single mode sets flag and holds pin low until flag cleared, except while frequency output runs.
// - repeat mode emits a low pulse on every match while frequency output is off, indefinitely.
// - writing flag 0 clears the alarm and releases the pin.
// - with auto clear set, reading status clears the flag.
// - battery sense enable resets to 0, gating battery compensation.
// - setting temp sense enable starts a 22 ms two-conversion cycle.
// - battery below 2.7 V forces battery sensing off, no compensation.
module rtc_trim_alarm
   import rtc_pkg::*;
#(
   parameter int CONV_CYCLES = RTC_CONV_CYCLES,
   parameter int PULSE_CYCLES = RTC_PULSE_CYCLES
)
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire rtc_reg_req_type i_reg,
   output logic [7:0] o_reg_rdata,
   input wire logic i_sec_tick,
   input wire rtc_cal_type i_cal,
   input wire logic i_on_battery,
   input wire logic i_bat_above_min,
   input wire logic i_freq_out_on,
   input wire logic [5:0] i_analog_trim_init,
   input wire logic [4:0] i_digital_trim_init,
   input wire logic signed [6:0] i_temp_at_steps,
   input wire logic signed [4:0] i_temp_dt_steps,
   output logic o_conv_start,
   output logic o_converting,
   output logic o_alarm_flag,
   output logic o_irq_pin_out,
   output logic o_irq_pin_oe
);
   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [1:0] pin_s3_q;
   logic [1:0] pin_q;
   wire logic [1:0] pin_raw = {i_bat_above_min, i_on_battery};

   genvar gp;
   generate
      for (gp = 0; gp < 2; gp++) begin : g_sync
         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               pin_s1_q[gp] <= 1'b0;
               pin_s2_q[gp] <= 1'b0;
               pin_s3_q[gp] <= 1'b0;
               pin_q[gp] <= 1'b0;
            end else begin
               pin_s1_q[gp] <= pin_raw[gp];
               pin_s2_q[gp] <= pin_s1_q[gp];
               pin_s3_q[gp] <= pin_s2_q[gp];
               // only levels seen on two samples in a row count, one-sample glitches are dropped
               if (pin_s2_q[gp] == pin_s3_q[gp]) begin
                  pin_q[gp] <= pin_s3_q[gp];
               end
            end
         end
      end
   endgenerate

   wire logic on_battery = pin_q[0];
   wire logic bat_ok = pin_q[1];

   // ****************************************************************
   // register decode
   // ****************************************************************
   logic [7:0] gain_reg_q;
   logic [7:0] gain_reg_d;
   logic [7:0] ctrl_q;
   logic [RTC_ALM_FIELDS-1:0][7:0] alm_q;
   logic flag_q;
   logic flag_d;
   logic [5:0] fat_q;
   logic [4:0] fdt_q;
   logic [4:0] gain_pend_q;
   logic [4:0] gain_act_q;

   wire logic wr_gain = i_reg.wr && (i_reg.addr == RTC_GAIN_ADDR);
   wire logic wr_ctrl = i_reg.wr && (i_reg.addr == RTC_CTRL_ADDR);
   wire logic wr_stat = i_reg.wr && (i_reg.addr == RTC_STAT_ADDR);
   wire logic rd_stat = i_reg.rd && (i_reg.addr == RTC_STAT_ADDR);
   wire logic wr_alm = i_reg.wr && (i_reg.addr >= RTC_ALM_FIRST)
                    && (i_reg.addr <= RTC_ALM_LAST);
   wire logic [7:0] alm_off = i_reg.addr - RTC_ALM_FIRST;
   wire logic temp_sense_enable = gain_reg_q[RTC_TSE_BIT];
   wire logic battery_sense_enable = gain_reg_q[RTC_BATTERY_SENSE_ENABLE_BIT];
   wire logic battery_sense_rate = gain_reg_q[RTC_BATTERY_SENSE_RATE_BIT];
   wire logic tse_rise = wr_gain && i_reg.wdata[RTC_TSE_BIT] && !temp_sense_enable;
   // the write that starts a cycle also carries the gain it must use
   wire logic [4:0] gain_next = (wr_gain && i_reg.wdata[RTC_TSE_BIT])
                              ? i_reg.wdata[4:0] : gain_pend_q;

   // low battery overrides whatever the host left in the enable
   always_comb begin
      gain_reg_d = gain_reg_q;
      if (wr_gain) begin
         gain_reg_d = i_reg.wdata;
      end
      if (!bat_ok) begin
         gain_reg_d[RTC_BATTERY_SENSE_ENABLE_BIT] = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gain_reg_q <= RTC_GAIN_RST;
         ctrl_q <= RTC_CTRL_RST;
         gain_pend_q <= 5'h00;
      end else begin
         gain_reg_q <= gain_reg_d;
         if (wr_ctrl) begin
            ctrl_q <= i_reg.wdata;
         end
         // second write of the pair, enable at 1, arms the gain
         gain_pend_q <= gain_next;
      end
   end

   genvar ga;
   generate
      for (ga = 0; ga < RTC_ALM_FIELDS; ga++) begin : g_alm_reg
         always_ff @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               alm_q[ga] <= RTC_ALM_RST;
            end else if (wr_alm && (alm_off == 8'(ga))) begin
               alm_q[ga] <= i_reg.wdata;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // read path
   // ****************************************************************
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (i_reg.addr == RTC_STAT_ADDR) begin
         rd_mux[RTC_FLAG_BIT] = flag_q;
      end else if (i_reg.addr == RTC_CTRL_ADDR) begin
         rd_mux = ctrl_q;
      end else if (i_reg.addr == RTC_GAIN_ADDR) begin
         rd_mux = gain_reg_q;
      end else if (i_reg.addr == RTC_FAT_ADDR) begin
         rd_mux = {2'b00, fat_q};
      end else if (i_reg.addr == RTC_FDT_ADDR) begin
         rd_mux = {3'b000, fdt_q};
      end else if (wr_alm || ((i_reg.addr >= RTC_ALM_FIRST)
                  && (i_reg.addr <= RTC_ALM_LAST))) begin
         rd_mux = alm_q[alm_off[2:0]];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg.rd) begin
         o_reg_rdata <= rd_mux;
      end
   end

   // ****************************************************************
   // battery mode sensing period
   // ****************************************************************
   logic [9:0] sec_cnt_q;
   wire logic bat_sense_on = on_battery && battery_sense_enable && bat_ok;
   wire logic [9:0] period = battery_sense_rate ? RTC_FAST_SECS : RTC_SLOW_SECS;
   wire logic period_hit = bat_sense_on && i_sec_tick
                        && (sec_cnt_q >= period - 10'd1);

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sec_cnt_q <= 10'h000;
      end else if (!bat_sense_on || period_hit) begin
         sec_cnt_q <= 10'h000;
      end else if (i_sec_tick) begin
         sec_cnt_q <= sec_cnt_q + 10'd1;
      end
   end

   // ****************************************************************
   // conversion sequencer
   // ****************************************************************
   rtc_sense_state_type state_q;
   rtc_sense_state_type state_d;
   logic [21:0] conv_cnt_q;
   wire logic start = tse_rise || period_hit;
   wire logic conv_done = (conv_cnt_q == 22'(CONV_CYCLES - 1));

   always_comb begin
      case (state_q)
         RTC_S_IDLE: state_d = start ? RTC_S_CONV : RTC_S_IDLE;
         RTC_S_CONV: state_d = conv_done ? RTC_S_APPLY : RTC_S_CONV;
         RTC_S_APPLY: state_d = RTC_S_IDLE;
         default: state_d = RTC_S_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= RTC_S_IDLE;
         conv_cnt_q <= 22'h000000;
         gain_act_q <= 5'h00;
      end else begin
         state_q <= state_d;
         if (state_q == RTC_S_CONV) begin
            conv_cnt_q <= conv_cnt_q + 22'd1;
         end else begin
            conv_cnt_q <= 22'h000000;
         end
         // gain only changes at a cycle boundary, never mid-conversion
         if (state_q == RTC_S_IDLE && start) begin
            gain_act_q <= gain_next;
         end
      end
   end

   assign o_conv_start = (state_q == RTC_S_IDLE) && start;
   assign o_converting = (state_q == RTC_S_CONV);

   // ****************************************************************
   // trim results
   // ****************************************************************
   logic [5:0] at_new;
   logic [4:0] dt_new;

   rtc_trim_scale u_scale (
      .i_gain(gain_act_q),
      .i_at_base(i_analog_trim_init),
      .i_at_steps(i_temp_at_steps),
      .i_dt_base(i_digital_trim_init),
      .i_dt_steps(i_temp_dt_steps),
      .o_at_final(at_new),
      .o_dt_final(dt_new)
   );

   // monitors have no write path at all
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fat_q <= 6'h00;
         fdt_q <= 5'h00;
      end else if (state_q == RTC_S_APPLY) begin
         fat_q <= at_new;
         fdt_q <= dt_new;
      end else if (!temp_sense_enable && !bat_sense_on) begin
         fat_q <= i_analog_trim_init;
         fdt_q <= i_digital_trim_init;
      end
   end

   // ****************************************************************
   // alarm compare
   // ****************************************************************
   logic [RTC_ALM_FIELDS-1:0] fld_ok;
   logic [RTC_ALM_FIELDS-1:0] fld_en;
   genvar gc;
   generate
      for (gc = 0; gc < RTC_ALM_FIELDS; gc++) begin : g_cmp
         assign fld_en[gc] = alm_q[gc][RTC_ALM_EN_BIT];
         assign fld_ok[gc] = !fld_en[gc]
            || (alm_q[gc][6:0] == i_cal.field[gc]);
      end
   endgenerate

   wire logic repeat_mode = ctrl_q[0];
   wire logic match = i_sec_tick && (|fld_en) && (&fld_ok);
   wire logic clr_wr = wr_stat && !i_reg.wdata[RTC_FLAG_BIT];
   wire logic clr_rd = rd_stat && ctrl_q[RTC_AUTOCLR_BIT];

   // a match in the clearing cycle keeps the flag set
   always_comb begin
      flag_d = flag_q;
      if (clr_wr || clr_rd) begin
         flag_d = 1'b0;
      end
      if (match) begin
         flag_d = 1'b1;
      end
   end

   // ****************************************************************
   // shared interrupt pin
   // ****************************************************************
   logic [16:0] pulse_cnt_q;
   wire logic pulse_on = (pulse_cnt_q != 17'h00000);

   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flag_q <= 1'b0;
         pulse_cnt_q <= 17'h00000;
      end else begin
         flag_q <= flag_d;
         if (match && repeat_mode) begin
            pulse_cnt_q <= 17'(PULSE_CYCLES);
         end else if (pulse_on) begin
            pulse_cnt_q <= pulse_cnt_q - 17'd1;
         end
      end
   end

   // frequency output owns the pin while it runs
   wire logic drive_low = !i_freq_out_on
      && (repeat_mode ? pulse_on : flag_q);

   assign o_alarm_flag = flag_q;
   assign o_irq_pin_out = 1'b0;
   assign o_irq_pin_oe = drive_low;
endmodule

// [hw/rtc_pkg.sv]
// shared constants and types of the trim and alarm block
package rtc_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] RTC_STAT_ADDR = 8'h07;
   localparam logic [7:0] RTC_CTRL_ADDR = 8'h08;
   localparam logic [7:0] RTC_GAIN_ADDR = 8'h0D;
   localparam logic [7:0] RTC_FAT_ADDR = 8'h0E;
   localparam logic [7:0] RTC_FDT_ADDR = 8'h0F;
   localparam logic [7:0] RTC_ALM_FIRST = 8'h10;
   localparam logic [7:0] RTC_ALM_LAST = 8'h15;
   localparam int RTC_ALM_FIELDS = 6;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int RTC_FLAG_BIT = 4;
   localparam int RTC_AUTOCLR_BIT = 7;
   localparam int RTC_TSE_BIT = 7;
   localparam int RTC_BATTERY_SENSE_ENABLE_BIT = 6;
   localparam int RTC_BATTERY_SENSE_RATE_BIT = 5;
   localparam int RTC_ALM_EN_BIT = 7;
   localparam logic [7:0] RTC_GAIN_RST = 8'h00;
   localparam logic [7:0] RTC_CTRL_RST = 8'h00;
   localparam logic [7:0] RTC_ALM_RST = 8'h00;
   localparam logic [5:0] RTC_AT_MAX = 6'h3F;
   localparam logic [3:0] RTC_DT_MAG_MAX = 4'hA;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int RTC_CLK_KHZ = 125000;
   localparam int RTC_CONV_MS = 22;
   localparam int RTC_CONV_CYCLES = RTC_CONV_MS * RTC_CLK_KHZ;
   localparam int RTC_PULSE_MS = 1;
   localparam int RTC_PULSE_CYCLES = RTC_PULSE_MS * RTC_CLK_KHZ;
   localparam int RTC_SLOW_MIN = 10;
   localparam int RTC_FAST_MIN = 1;
   localparam logic [9:0] RTC_SLOW_SECS = 10'(RTC_SLOW_MIN * 60);
   localparam logic [9:0] RTC_FAST_SECS = 10'(RTC_FAST_MIN * 60);

   // ****************************************************************
   // types
   // ****************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtc_reg_req_type;

   // seconds, minutes, hours, date, month, weekday (index 0..5)
   typedef struct packed {
      logic [RTC_ALM_FIELDS-1:0][6:0] field;
   } rtc_cal_type;

   typedef enum logic [2:0] {
      RTC_S_IDLE = 3'b001,
      RTC_S_CONV = 3'b010,
      RTC_S_APPLY = 3'b100
   } rtc_sense_state_type;
endpackage

// [hw/rtc_trim_scale.sv]
// gain scaling of analog trim steps and digital trim correction
module rtc_trim_scale
   import rtc_pkg::*;
(
   input wire logic [4:0] i_gain,
   input wire logic [5:0] i_at_base,
   input wire logic signed [6:0] i_at_steps,
   input wire logic [4:0] i_dt_base,
   input wire logic signed [4:0] i_dt_steps,
   output logic [5:0] o_at_final,
   output logic [4:0] o_dt_final
);
   // ****************************************************************
   // analog path
   // ****************************************************************
   // multiplier in sixteenths: 16 - low bits, or 17 + low bits up to 32
   wire logic [5:0] mult = i_gain[4] ? 6'(17 + i_gain[3:0])
                                    : 6'(16 - i_gain[3:0]);
   wire logic signed [13:0] prod = i_at_steps * $signed({1'b0, mult});
   wire logic signed [10:0] at_sum = $signed({5'h00, i_at_base})
                                   + $signed({prod[13], prod[13:4]});
   // clamp instead of wrapping, a wrap would swing the crystal far off
   assign o_at_final = at_sum[10] ? 6'h00
                     : (at_sum > 11'sd63) ? RTC_AT_MAX : at_sum[5:0];

   // ****************************************************************
   // digital path, sign and magnitude
   // ****************************************************************
   wire logic signed [6:0] dt_base_s = i_dt_base[4]
      ? -$signed({3'h0, i_dt_base[3:0]})
      : $signed({3'h0, i_dt_base[3:0]});
   wire logic signed [6:0] dt_sum = dt_base_s
      + $signed({{2{i_dt_steps[4]}}, i_dt_steps});
   wire logic [6:0] dt_abs = dt_sum[6] ? 7'(-dt_sum) : 7'(dt_sum);
   wire logic [3:0] dt_mag = (dt_abs > {3'h0, RTC_DT_MAG_MAX})
      ? RTC_DT_MAG_MAX : dt_abs[3:0];
   assign o_dt_final = {dt_sum[6] && (dt_mag != 4'h0), dt_mag};
endmodule

// [test/rtc_trim_alarm_asserts.sv]
// concurrent checks on the ports of the trim and alarm block
module rtc_trim_alarm_asserts
   import rtc_pkg::*;
#(
   parameter int CONV_CYCLES = 20,
   parameter int PULSE_CYCLES = 5
)
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire rtc_reg_req_type i_reg,
   input wire logic [7:0] o_reg_rdata,
   input wire logic i_sec_tick,
   input wire rtc_cal_type i_cal,
   input wire logic i_on_battery,
   input wire logic i_freq_out_on,
   input wire logic o_conv_start,
   input wire logic o_converting,
   input wire logic o_alarm_flag,
   input wire logic o_irq_pin_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);
   // ****************************************************************
   // shadow registers, rebuilt from host writes
   // ****************************************************************
   logic [5:0][7:0] alm_q;
   logic rep_q, aclr_q, battery_sense_enable_q;
   logic [5:0] en, eq;
   logic [31:0] cv_q, oe_q;
   logic [3:0] fq_q;
   wire [7:0] a = i_reg.addr;
   wire wr_gain = i_reg.wr && a == RTC_GAIN_ADDR;
   wire rd_stat = i_reg.rd && a == RTC_STAT_ADDR;
   wire hit = i_sec_tick && (|en) && ((eq | ~en) == 6'h3F);
   // freq output off now and four cycles earlier; the block itself reads it without a sync delay
   wire quiet = !i_freq_out_on && !fq_q[3];
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         en[k] = alm_q[k][RTC_ALM_EN_BIT];
         eq[k] = alm_q[k][6:0] == i_cal.field[k];
      end
   end
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         alm_q <= '0;
         rep_q <= 1'b0;
         aclr_q <= 1'b0;
         battery_sense_enable_q <= 1'b0;
      end else if (i_reg.wr) begin
         if (a >= RTC_ALM_FIRST && a <= RTC_ALM_LAST)
            alm_q[a[2:0]] <= i_reg.wdata;
         if (a == RTC_CTRL_ADDR) begin
            rep_q <= i_reg.wdata[0];
            aclr_q <= i_reg.wdata[RTC_AUTOCLR_BIT];
         end
         if (wr_gain)
            battery_sense_enable_q <= i_reg.wdata[RTC_BATTERY_SENSE_ENABLE_BIT];
      end
   end
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cv_q <= '0;
         oe_q <= '0;
         fq_q <= '0;
      end else begin
         fq_q <= {fq_q[2:0], i_freq_out_on};
         cv_q <= o_converting ? cv_q + 1 : '0;
         oe_q <= o_irq_pin_oe ? oe_q + 1 : '0;
      end
   end
   // ****************************************************************
   // assertions
   // ****************************************************************
   a_conv_cause: assert property (
      o_conv_start |-> (wr_gain && i_reg.wdata[RTC_TSE_BIT])
         || (i_sec_tick && i_on_battery && battery_sense_enable_q))
      else $error("conversion started without cause");
   a_conv_length: assert property (
      $fell(o_converting) |-> cv_q == CONV_CYCLES)
      else $error("conversion wait has wrong length");
   a_analog_upper: assert property (
      i_reg.rd && a == RTC_FAT_ADDR |=> o_reg_rdata[7:6] == 2'b00)
      else $error("analog monitor upper bits set");
   a_digital_upper: assert property (
      i_reg.rd && a == RTC_FDT_ADDR |=> o_reg_rdata[7:5] == 3'b000)
      else $error("digital monitor upper bits set");
   a_flag_cause: assert property (
      $rose(o_alarm_flag) |-> $past(hit))
      else $error("alarm flag rose without a match");
   a_flag_set: assert property (
      hit |=> o_alarm_flag)
      else $error("match did not set alarm flag");
   a_single_pin: assert property (
      !rep_q && quiet |-> o_irq_pin_oe == o_alarm_flag)
      else $error("single mode pin differs from flag");
   a_flag_clear: assert property (
      i_reg.wr && a == RTC_STAT_ADDR && !i_reg.wdata[RTC_FLAG_BIT] && !hit
      |=> !o_alarm_flag)
      else $error("flag write of zero did not clear");
   a_auto_clear: assert property (
      rd_stat && aclr_q && !hit |=> !o_alarm_flag)
      else $error("status read did not clear flag");
   a_repeat_pulse: assert property (
      hit && rep_q && quiet |=> o_irq_pin_oe && o_alarm_flag)
      else $error("repeat match gave no pin pulse");
   a_pulse_width: assert property (
      rep_q && $fell(o_irq_pin_oe) |-> oe_q == PULSE_CYCLES)
      else $error("repeat pulse has wrong width");
endmodule

bind rtc_trim_alarm rtc_trim_alarm_asserts #(
   .CONV_CYCLES(CONV_CYCLES),
   .PULSE_CYCLES(PULSE_CYCLES)
) u_asserts (
   .i_core_clk(i_core_clk),
   .i_reset_n(i_reset_n),
   .i_reg(i_reg),
   .o_reg_rdata(o_reg_rdata),
   .i_sec_tick(i_sec_tick),
   .i_cal(i_cal),
   .i_on_battery(i_on_battery),
   .i_freq_out_on(i_freq_out_on),
   .o_conv_start(o_conv_start),
   .o_converting(o_converting),
   .o_alarm_flag(o_alarm_flag),
   .o_irq_pin_oe(o_irq_pin_oe)
);

// [test/rtc_host_model.sv]
// host model driving the internal register port
module rtc_host_model
   import rtc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic [7:0] i_rdata,
   output rtc_reg_req_type o_reg
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_reg = '0;
   task automatic put(input logic [7:0] adr, input logic [7:0] dat);
      @(negedge i_core_clk);
      o_reg = '{wr: 1'b1, rd: 1'b0, addr: adr, wdata: dat};
      @(negedge i_core_clk);
      o_reg.wr = 1'b0;
      // stale data must not look valid
      o_reg.wdata = ~dat;
   endtask
   task automatic get(input logic [7:0] adr, output logic [7:0] dat);
      @(negedge i_core_clk);
      o_reg.addr = adr;
      o_reg.rd = 1'b1;
      @(negedge i_core_clk);
      o_reg.rd = 1'b0;
      dat = i_rdata;
   endtask
   // two writes, sensing off then on, same gain; md = {battery_sense_enable, battery_sense_rate}
   task automatic set_gain(input logic [4:0] g, input logic [1:0] md);
      if (g[4:3] == 2'b01)
         g = 5'h08;
      put(RTC_GAIN_ADDR, {1'b0, md, g});
      put(RTC_GAIN_ADDR, {1'b1, md, g});
   endtask
endmodule

// [test/rtc_trim_alarm_test.sv]
// self-checking bench of the trim and alarm block
module rtc_trim_alarm_test
   import rtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PULSE = 5;
   logic clk, rst_n, tick, on_bat, bat_ok, freq_on;
   logic conv_start, conv, flag, pin_oe, pin_out;
   rtc_reg_req_type req;
   rtc_cal_type cal;
   logic [5:0] at_init;
   logic [4:0] dt_init;
   logic signed [6:0] at_st;
   logic signed [4:0] dt_st;
   logic [7:0] rdata, v;
   logic [7:0] sc [6];
   logic [4:0] g_tab [4] = '{5'h08, 5'h1F, 5'h10, 5'h00};
   logic signed [6:0] a_tab [4] = '{7'sh08, 7'sh08, -7'sh08, 7'sh05};
   logic signed [4:0] d_tab [4] = '{5'sh02, -5'sh08, -5'sh0F, 5'sh07};
   int fails, cmp_count, starts, n;

   rtc_trim_alarm #(.CONV_CYCLES(20), .PULSE_CYCLES(PULSE)) DUT (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_reg(req),
      .o_reg_rdata(rdata), .i_sec_tick(tick), .i_cal(cal),
      .i_on_battery(on_bat), .i_bat_above_min(bat_ok),
      .i_freq_out_on(freq_on), .i_analog_trim_init(at_init),
      .i_digital_trim_init(dt_init), .i_temp_at_steps(at_st),
      .i_temp_dt_steps(dt_st), .o_conv_start(conv_start),
      .o_converting(conv), .o_alarm_flag(flag),
      .o_irq_pin_out(pin_out), .o_irq_pin_oe(pin_oe)
   );
   rtc_host_model u_host (.i_core_clk(clk), .i_rdata(rdata), .o_reg(req));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (conv_start === 1'b1)
         starts++;
   end
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] adr, input logic [7:0] exp);
      u_host.get(adr, v);
      check(v, exp);
   endtask
   task automatic ticks(input int k);
      repeat (k) begin
         @(negedge clk);
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
      end
   endtask
   task automatic alarms();
      for (int k = 0; k < 6; k++)
         u_host.put(RTC_ALM_FIRST + 8'(k), sc[k]);
   endtask
   function automatic logic [7:0] exp_at(input logic [4:0] g);
      int m;
      m = g[4] ? 17 + int'(g[3:0]) : 16 - int'(g[3:0]);
      return 8'(int'(at_init) + ((int'(at_st) * m) >>> 4));
   endfunction
   function automatic logic [7:0] exp_dt();
      int s;
      s = dt_init[4] ? -int'(dt_init[3:0]) : int'(dt_init[3:0]);
      s = s + int'(dt_st);
      s = s > 10 ? 10 : (s < -10 ? -10 : s);
      return s < 0 ? 8'(16 - s) : 8'(s);
   endfunction
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      wrap_up();
   end
   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      {rst_n, tick, on_bat, freq_on, at_st, dt_st} = '0;
      bat_ok = 1'b1;
      cal = '0;
      at_init = 6'h14;
      dt_init = 5'h03;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      rchk(RTC_GAIN_ADDR, 8'h00);
      rchk(RTC_FAT_ADDR, 8'h14);
      rchk(RTC_FDT_ADDR, 8'h03);
      rchk(8'h30, 8'h00);
      for (int k = 0; k < 6; k++) begin
         rchk(RTC_ALM_FIRST + 8'(k), 8'h00);
         u_host.put(RTC_ALM_FIRST + 8'(k), 8'h81 + 8'(k));
         rchk(RTC_ALM_FIRST + 8'(k), 8'h81 + 8'(k));
         u_host.put(RTC_ALM_FIRST + 8'(k), 8'h00);
      end
      u_host.put(8'h16, 8'hFF);
      rchk(8'h16, 8'h00);
      for (int t = 0; t < 4; t++) begin
         at_st = a_tab[t];
         dt_st = d_tab[t];
         u_host.set_gain(g_tab[t], 2'b00);
         n = 0;
         while (conv !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
         end
         repeat (2) @(negedge clk);
         rchk(RTC_FAT_ADDR, exp_at(g_tab[t]));
         rchk(RTC_FDT_ADDR, exp_dt());
      end
      u_host.put(RTC_FAT_ADDR, 8'hFF);
      u_host.put(RTC_FDT_ADDR, 8'hFF);
      rchk(RTC_FAT_ADDR, exp_at(5'h00));
      rchk(RTC_FDT_ADDR, exp_dt());
      on_bat = 1'b1;
      starts = 0;
      ticks(180);
      check(8'(starts), 8'h00);
      u_host.put(RTC_GAIN_ADDR, 8'h60);
      starts = 0;
      ticks(180);
      check(8'(starts), 8'h03);
      u_host.put(RTC_GAIN_ADDR, 8'h40);
      starts = 0;
      ticks(1800);
      check(8'(starts), 8'h03);
      bat_ok = 1'b0;
      repeat (6) @(negedge clk);
      u_host.put(RTC_GAIN_ADDR, 8'h60);
      rchk(RTC_GAIN_ADDR, 8'h20);
      starts = 0;
      ticks(180);
      check(8'(starts), 8'h00);
      on_bat = 1'b0;
      bat_ok = 1'b1;
      u_host.put(RTC_CTRL_ADDR, 8'h00);
      sc = '{8'h00, 8'hB0, 8'h91, 8'h81, 8'h81, 8'h00};
      alarms();
      cal.field = {7'h03, 7'h01, 7'h01, 7'h11, 7'h29, 7'h00};
      ticks(1);
      check(8'(flag), 8'h00);
      cal.field[1] = 7'h30;
      ticks(1);
      check(8'({flag, pin_oe}), 8'h03);
      check(8'(pin_out), 8'h00);
      cal.field[0] = 7'h01;
      ticks(1);
      check(8'({flag, pin_oe}), 8'h03);
      u_host.get(RTC_STAT_ADDR, v);
      check(8'(v[RTC_FLAG_BIT]), 8'h01);
      u_host.put(RTC_STAT_ADDR, 8'h00);
      check(8'({flag, pin_oe}), 8'h00);
      u_host.put(RTC_CTRL_ADDR, 8'h80);
      cal.field[0] = 7'h00;
      ticks(1);
      u_host.get(RTC_STAT_ADDR, v);
      check(8'(v[RTC_FLAG_BIT]), 8'h01);
      check(8'({flag, pin_oe}), 8'h00);
      u_host.put(RTC_CTRL_ADDR, 8'h01);
      sc = '{8'hB0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      alarms();
      cal.field[0] = 7'h30;
      repeat (2) begin
         ticks(1);
         n = 0;
         while (pin_oe === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
         end
         check(8'(n), 8'(PULSE));
      end
      freq_on = 1'b1;
      repeat (6) @(negedge clk);
      ticks(1);
      check(8'(pin_oe), 8'h00);
      wrap_up();
   end
endmodule
